// [xps_pkg.sv]
// ==========================================================
// Shared constants and types for the crosspoint control block
package xps_pkg;

    // ==========================================================
    // Array geometry
    localparam int XPS_NUM_OUT = 8;
    localparam int XPS_NUM_IN = 16;
    localparam int XPS_SEL_BITS = 4;
    localparam int XPS_ADDR_BITS = 3;
    localparam int XPS_FIELD_BITS = XPS_SEL_BITS + 1;
    localparam int XPS_WORD_BITS = XPS_NUM_OUT * XPS_FIELD_BITS;

    // ==========================================================
    // Field layout inside one 5-bit field (bit 0 shifts in last)
    localparam int XPS_FLD_EN_POS = 0;
    localparam int XPS_FLD_SEL_LO = 1;

    // ==========================================================
    // Reset values
    localparam logic [XPS_WORD_BITS-1:0] XPS_WORD_RST = 40'h00_0000_0000;
    localparam logic [1:0] XPS_SYNC_RST = 2'h0;

    // Input select in field order: first shifted bit is select LSB
    typedef struct packed {
        logic sel_b0;
        logic sel_b1;
        logic sel_b2;
        logic sel_b3;
        logic en;
    } xps_field_t;

    // Parallel programming bundle
    typedef struct packed {
        logic [XPS_ADDR_BITS-1:0] addr;
        xps_field_t field;
    } xps_par_t;

    // Binary input number held in a field
    function automatic logic [XPS_SEL_BITS-1:0] xps_sel_of(
        input xps_field_t f
    );
        xps_sel_of = {f.sel_b3, f.sel_b2, f.sel_b1, f.sel_b0};
    endfunction : xps_sel_of

endpackage : xps_pkg

// [xps_field_decode.sv]
`timescale 1ns/1ps
// ==========================================================
// Decodes one latched field into a one-of-sixteen select and enable
module xps_field_decode
    import xps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input xps_field_t field,
    input wire logic out_reset_n,
    output logic [XPS_NUM_IN-1:0] sel_onehot,
    output logic out_en
);

    wire logic [XPS_SEL_BITS-1:0] sel_num;
    wire logic en_live;

    // Enable is gated off at once by the reset pin
    assign sel_num = xps_sel_of(field);
    assign en_live = field.en & out_reset_n;
    // Select bits do nothing while the output is disabled
    assign sel_onehot = en_live ? (16'h0001 << sel_num) : 16'h0000;
    assign out_en = en_live;

    // ==========================================================
    // Checks
    property p_onehot_sel;
        @(posedge clk) disable iff (!rst_n)
        out_en |-> (sel_onehot == (16'h0001 << $sampled(sel_num)));
    endproperty
    a_onehot_sel: assert property (p_onehot_sel)
        else $error("enabled output selects wrong input");

    property p_disabled_quiet;
        @(posedge clk) disable iff (!rst_n)
        (!field.en || !out_reset_n) |-> (sel_onehot == 16'h0000 && !out_en);
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled output still drives a select");

endmodule : xps_field_decode

// [xps_ctrl.sv]
`timescale 1ns/1ps
// ==========================================================
// Crosspoint switch control: serial/parallel loader and latches
// How it works
// - chip select high ignores clock and transfer
// - loading happens only on falling prog clock
// - serial mode shifts serial input each fall while transfer high
// - chain output is input delayed 40 shifts
// - parallel mode writes addressed 5-bit slice
// - transfer low with select low and reset pin high follows register
// - transfer high holds latches isolated
// - reset pin disables outputs, state kept
// - mode low serial, high parallel
// - output address binary, bit 0 least significant
// - four select bits form binary input number
// - fifth bit enables addressed output
// - each output owns field; disabled ignores select
module xps_ctrl
    import xps_pkg::*;
#(
    parameter int NUM_OUT = XPS_NUM_OUT,
    parameter int WORD_BITS = XPS_WORD_BITS
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic prog_clk,
    input wire logic chip_sel_n,
    input wire logic xfer_n,
    input wire logic load_mode_select,
    input wire logic serial_in,
    input wire logic out_addr_0,
    input wire logic out_addr_1,
    input wire logic out_addr_2,
    input wire logic in_sel_0,
    input wire logic in_sel_1,
    input wire logic in_sel_2,
    input wire logic in_sel_3,
    input wire logic out_enable_bit,
    input wire logic out_reset_n,
    output logic serial_out,
    output logic [NUM_OUT-1:0][XPS_NUM_IN-1:0] out_select,
    output logic [NUM_OUT-1:0] out_en,
    output logic [WORD_BITS-1:0] latch_word
);

    // ==========================================================
    // Reset release synchroniser
    logic [1:0] rst_sync_q;
    wire logic rst_n_s;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_sync_q <= XPS_SYNC_RST;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n_s = rst_sync_q[1];

    // ==========================================================
    // Field access helper
    function automatic xps_field_t field_of(
        input logic [XPS_WORD_BITS-1:0] w,
        input logic [XPS_ADDR_BITS-1:0] idx
    );
        field_of = w[idx*XPS_FIELD_BITS +: XPS_FIELD_BITS];
    endfunction : field_of

    // ==========================================================
    // Pin bundling and edge detection
    logic prog_clk_q;
    logic [XPS_WORD_BITS-1:0] shift_q;
    logic [XPS_WORD_BITS-1:0] shift_d;
    logic [XPS_WORD_BITS-1:0] latch_q;
    logic serial_out_q;
    wire xps_par_t par;
    wire logic clk_fall;
    wire logic load_ok;
    wire logic ser_ev;
    wire logic par_ev;
    wire logic follow;

    // Address bits in binary, bit 0 least significant; one driver for all
    assign par = '{addr: {out_addr_2, out_addr_1, out_addr_0},
                   field: '{sel_b0: in_sel_0, sel_b1: in_sel_1,
                            sel_b2: in_sel_2, sel_b3: in_sel_3,
                            en: out_enable_bit}};

    // Only a high-to-low step of the programming clock loads
    assign clk_fall = prog_clk_q & ~prog_clk;
    // Chip select high blocks both load and transfer
    assign load_ok = clk_fall & ~chip_sel_n & xfer_n;
    // Mode pin low selects serial, high parallel
    assign ser_ev = load_ok & ~load_mode_select;
    assign par_ev = load_ok & load_mode_select;
    // Latches open only with select and transfer low, reset idle
    assign follow = ~chip_sel_n & ~xfer_n & out_reset_n;

    // Next shift register value
    always_comb
    begin
        shift_d = shift_q;
        if (ser_ev)
            shift_d = {shift_q[XPS_WORD_BITS-2:0], serial_in};
        else if (par_ev)
            shift_d[par.addr*XPS_FIELD_BITS +: XPS_FIELD_BITS] =
                par.field;
    end

    // ==========================================================
    // Storage; the reset pin does not touch any of it
    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            prog_clk_q <= 1'b0;
        else
            prog_clk_q <= prog_clk;
    end

    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            shift_q <= XPS_WORD_RST;
        else
            shift_q <= shift_d;
    end

    // Chain output takes the bit leaving the last stage
    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            serial_out_q <= 1'b0;
        else if (ser_ev)
            serial_out_q <= shift_q[XPS_WORD_BITS-1];
    end

    // Switch latches: follow while open, hold otherwise
    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            latch_q <= XPS_WORD_RST;
        else if (follow)
            latch_q <= shift_q;
    end

    assign serial_out = serial_out_q;
    assign latch_word = latch_q;

    // ==========================================================
    // Per-output decode
    for (genvar k = 0; k < NUM_OUT; k++)
    begin : g_out
        xps_field_decode u_dec (
            .clk(clk),
            .rst_n(rst_n_s),
            .field(field_of(latch_q, XPS_ADDR_BITS'(k))),
            .out_reset_n(out_reset_n),
            .sel_onehot(out_select[k]),
            .out_en(out_en[k])
        );

        // Each enable tracks its latched field bit and the pin
        property p_en_map;
            @(posedge clk) disable iff (!rst_n_s)
            out_en[k] == (latch_q[k*XPS_FIELD_BITS] & out_reset_n);
        endproperty
        a_en_map: assert property (p_en_map)
            else $error("output enable does not match its field");

        // An enabled output feeds exactly one input
        property p_one_input;
            @(posedge clk) disable iff (!rst_n_s)
            out_en[k] |-> $onehot(out_select[k]);
        endproperty
        a_one_input: assert property (p_one_input)
            else $error("enabled output feeds other than one input");
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n_s);

    // Load steps: clock high, then low with the qualifiers at the fall
    sequence s_fall;
        prog_clk ##1 !prog_clk;
    endsequence

    sequence s_ser_load;
        s_fall ##0 (!chip_sel_n && xfer_n && !load_mode_select);
    endsequence

    sequence s_par_load;
        s_fall ##0 (!chip_sel_n && xfer_n && load_mode_select);
    endsequence

    // Deselected device keeps its register and latch contents
    property p_cs_ignore;
        chip_sel_n |=> (shift_q == $past(shift_q)) && $stable(latch_q);
    endproperty
    a_cs_ignore: assert property (p_cs_ignore)
        else $error("state changed while chip select high");

    property p_no_rise_load;
        (!prog_clk ##1 prog_clk) |=> $stable(shift_q);
    endproperty
    a_no_rise_load: assert property (p_no_rise_load)
        else $error("register loaded on rising clock");

    property p_ser_shift;
        s_ser_load |=> (shift_q[0] == $past(serial_in))
            && (shift_q[XPS_WORD_BITS-1:1] ==
                $past(shift_q[XPS_WORD_BITS-2:0]));
    endproperty
    a_ser_shift: assert property (p_ser_shift)
        else $error("serial shift wrong");

    property p_chain_out;
        s_ser_load |=> serial_out == $past(shift_q[XPS_WORD_BITS-1]);
    endproperty
    a_chain_out: assert property (p_chain_out)
        else $error("chain output not delayed by forty");

    property p_par_write;
        s_par_load |=> field_of(shift_q, $past(par.addr)) == $past(par.field);
    endproperty
    a_par_write: assert property (p_par_write)
        else $error("parallel field not written");

    property p_par_others;
        s_par_load |=> ((shift_q ^ $past(shift_q)) &
            ~(40'h00_0000_001f << ($past(par.addr) * 5))) == 40'h00_0000_0000;
    endproperty
    a_par_others: assert property (p_par_others)
        else $error("parallel write touched another field");

    // Open latches copy the register one cycle later
    property p_follow;
        (!chip_sel_n && !xfer_n && out_reset_n) |=> latch_q == $past(shift_q);
    endproperty
    a_follow: assert property (p_follow)
        else $error("open latches did not follow register");

    // Closed latches ignore the register
    property p_hold;
        xfer_n |=> $stable(latch_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("latches changed while closed");

    // Pin reset silences every output at once
    property p_reset_off;
        !out_reset_n |-> (out_en == '0) && (out_select == '0);
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("reset pin did not disable outputs");

    // Pin reset leaves register and latch contents alone
    property p_reset_keep;
        (!out_reset_n && !clk_fall) |=> (shift_q == $past(shift_q))
            && $stable(latch_q);
    endproperty
    a_reset_keep: assert property (p_reset_keep)
        else $error("reset pin altered stored contents");

    // Loading is refused while the latches are open
    property p_open_no_load;
        (clk_fall && !xfer_n) |=> (shift_q == $past(shift_q));
    endproperty
    a_open_no_load: assert property (p_open_no_load)
        else $error("register loaded with transfer low");

    // Without a falling programming clock the register holds
    property p_idle_keep;
        !(prog_clk_q && !prog_clk) |=> (shift_q == $past(shift_q));
    endproperty
    a_idle_keep: assert property (p_idle_keep)
        else $error("register changed without a falling clock");

    // Chain output moves only on a serial shift
    property p_chain_hold;
        !ser_ev |=> $stable(serial_out);
    endproperty
    a_chain_hold: assert property (p_chain_hold)
        else $error("chain output moved without a shift");

    // Parallel loads leave the chain output alone
    property p_par_chain_quiet;
        s_par_load |=> $stable(serial_out);
    endproperty
    a_par_chain_quiet: assert property (p_par_chain_quiet)
        else $error("parallel load moved the chain output");

    // Address pins weigh in binary: enable lands in the addressed field
    property p_addr_order;
        s_par_load |=> shift_q[$past({out_addr_2, out_addr_1, out_addr_0})
            * XPS_FIELD_BITS] == $past(out_enable_bit);
    endproperty
    a_addr_order: assert property (p_addr_order)
        else $error("parallel enable landed in the wrong field");

endmodule : xps_ctrl

// [xps_prog_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Controller that drives the programming pins of the block
module xps_prog_model
(
    input wire logic clk,
    output logic prog_clk,
    output logic chip_sel_n,
    output logic xfer_n,
    output logic load_mode_select,
    output logic serial_in,
    output logic [2:0] addr,
    output logic [3:0] sel,
    output logic en
);
    // Idle pin levels at time zero; mode is always driven
    initial
    begin
        prog_clk = 1'b1;
        chip_sel_n = 1'b1;
        xfer_n = 1'b1;
        load_mode_select = 1'b0;
        {serial_in, addr, sel, en} = 9'h000;
    end

    // Chip select level, changed off the sampling edge
    task automatic pick(input logic n);
        @(negedge clk);
        chip_sel_n <= n;
    endtask : pick

    // One load: data set with clock high, clock falls, then released
    // f is a field in word order {sel0, sel1, sel2, sel3, enable}
    task automatic load(input logic md, input logic [2:0] a,
        input logic [4:0] f);
        @(negedge clk);
        prog_clk <= 1'b1;
        load_mode_select <= md;
        serial_in <= f[0];
        addr <= a;
        sel <= {f[1], f[2], f[3], f[4]};
        en <= f[0];
        @(negedge clk);
        prog_clk <= 1'b0;
        @(negedge clk);
        prog_clk <= 1'b1;
        // Released data lines show the inverse, not a stale value
        serial_in <= ~f[0];
        addr <= ~a;
        sel <= ~{f[1], f[2], f[3], f[4]};
        en <= ~f[0];
    endtask : load

    // Transfer strobe pulsed low only after shifting is complete
    task automatic xfer();
        @(negedge clk);
        xfer_n <= 1'b0;
        repeat (2) @(negedge clk);
        xfer_n <= 1'b1;
    endtask : xfer
endmodule : xps_prog_model

// [test_xps_ctrl.sv]
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the crosspoint control block
module test_xps_ctrl;
    import xps_pkg::*;
    logic clk, rstn, out_reset_n, serial_out;
    logic prog_clk, chip_sel_n, xfer_n, load_mode_select, serial_in, en;
    logic [2:0] addr;
    logic [3:0] sel;
    logic [XPS_NUM_OUT-1:0][XPS_NUM_IN-1:0] out_select;
    logic [XPS_NUM_OUT-1:0] out_en;
    logic [XPS_WORD_BITS-1:0] latch_word, w1, w2, w3;
    int err_count, n_compared;

    // ==========================================================
    // Design, controller model and clock
    xps_ctrl i_xps_ctrl (.clk(clk), .rstn(rstn), .prog_clk(prog_clk),
        .chip_sel_n(chip_sel_n), .xfer_n(xfer_n),
        .load_mode_select(load_mode_select), .serial_in(serial_in),
        .out_addr_0(addr[0]), .out_addr_1(addr[1]), .out_addr_2(addr[2]),
        .in_sel_0(sel[0]), .in_sel_1(sel[1]), .in_sel_2(sel[2]),
        .in_sel_3(sel[3]), .out_enable_bit(en), .out_reset_n(out_reset_n),
        .serial_out(serial_out), .out_select(out_select),
        .out_en(out_en), .latch_word(latch_word));
    xps_prog_model i_xps_prog_model (.clk(clk), .prog_clk(prog_clk),
        .chip_sel_n(chip_sel_n), .xfer_n(xfer_n),
        .load_mode_select(load_mode_select), .serial_in(serial_in),
        .addr(addr), .sel(sel), .en(en));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ==========================================================
    // Compare, verdict and word helpers
    task automatic check(input string what, input logic [39:0] seen,
        input logic [39:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // Word with distinct input numbers and a mix of enables
    function automatic logic [39:0] mk(input int s);
        logic [3:0] n;
        mk = 40'h00_0000_0000;
        for (int k = 0; k < 8; k++)
        begin
            n = 4'((k * 5 + s) % 16);
            mk[5*k+:5] = {n[0], n[1], n[2], n[3], 1'((k + s) % 3 != 0)};
        end
    endfunction : mk

    // Latched word and per-output decode; on is the pin reset level
    task automatic chk_out(input logic [39:0] w, input logic on);
        logic [3:0] n;
        check("latch_word", latch_word, w);
        for (int k = 0; k < 8; k++)
        begin
            n = {w[5*k+1], w[5*k+2], w[5*k+3], w[5*k+4]};
            check("out_en", out_en[k], w[5*k] & on);
            check("out_select", out_select[k],
                (w[5*k] & on) ? 40'h1 << n : 40'h0);
        end
    endtask : chk_out

    // Serial word, highest output first, checking the chain output
    task automatic shift(input logic [39:0] w, input logic [39:0] old);
        for (int i = 39; i >= 0; i--)
        begin
            i_xps_prog_model.load(1'b0, 3'h0, {4'h0, w[i]});
            if (!chip_sel_n)
                check("serial_out", serial_out, old[i]);
        end
    endtask : shift

    // ==========================================================
    // Watchdog and main sequence
    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        err_count = 0;
        n_compared = 0;
        rstn = 1'b0;
        out_reset_n = 1'b1;
        w1 = mk(1);
        w2 = mk(6);
        w3 = mk(11);
        repeat (4) @(negedge clk);
        rstn <= 1'b1;
        repeat (3) @(negedge clk);
        chk_out(40'h0, 1'b1);
        i_xps_prog_model.pick(1'b0);
        shift(w1, 40'h0);
        chk_out(40'h0, 1'b1);
        i_xps_prog_model.xfer();
        chk_out(w1, 1'b1);
        shift(w2, w1);
        i_xps_prog_model.pick(1'b1);
        i_xps_prog_model.xfer();
        chk_out(w1, 1'b1);
        shift(w3, w2);
        i_xps_prog_model.pick(1'b0);
        i_xps_prog_model.xfer();
        chk_out(w2, 1'b1);
        for (int k = 0; k < 8; k++)
            i_xps_prog_model.load(1'b1, 3'(k), w3[5*k+:5]);
        i_xps_prog_model.xfer();
        chk_out(w3, 1'b1);
        @(negedge clk);
        out_reset_n <= 1'b0;
        @(negedge clk);
        chk_out(w3, 1'b0);
        out_reset_n <= 1'b1;
        @(negedge clk);
        chk_out(w3, 1'b1);
        tally_and_finish();
    end
endmodule : test_xps_ctrl
